// *** src/pfi_pkg.sv ***
// Shared constants and types for the pulse and frequency input block.
package pfi_pkg;
   // System clock rate and derived timebase.
   localparam int unsigned CLK_HZ = 50_000_000; // System clock in Hz.
   localparam int unsigned TICK_MS = 1; // Timebase tick length in ms.
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS; // Clocks per tick.
   localparam int unsigned MS_PER_S = 1000; // Ticks per second.
   localparam int unsigned SEC_PER_DAY = 86400; // Seconds in one day.
   // Register byte offsets.
   localparam logic [7:0] OFF_CTRL = 8'h00; // Mode and processing control.
   localparam logic [7:0] OFF_FILTER = 8'h04; // Debounce filter time in ms.
   localparam logic [7:0] OFF_CYCLE = 8'h08; // Measurement cycle in seconds.
   localparam logic [7:0] OFF_TOD = 8'h0c; // Time of day in seconds.
   localparam logic [7:0] OFF_DAYRST = 8'h10; // Daily total clear time.
   localparam logic [7:0] OFF_VALUE = 8'h14; // Last processed value.
   localparam logic [7:0] OFF_STATUS = 8'h18; // Status flags.
   localparam logic [7:0] OFF_LIVE = 8'h1c; // Live accumulator of current mode.
   // Control register fields.
   localparam int unsigned CTRL_MODE_LSB = 0; // Two bits of input mode.
   localparam int unsigned CTRL_RED_LSB = 2; // Three bits of reduction.
   localparam int unsigned CTRL_HOLD_LSB = 5; // Three bits of hold setting.
   localparam int unsigned CTRL_RNG_LSB = 8; // Two bits of range handling.
   localparam int unsigned CTRL_WIN_LSB = 16; // Four bits of window length.
   // Status register fields.
   localparam int unsigned ST_ERR = 0; // Last value was an error code.
   localparam int unsigned ST_BELOW = 1; // Last value was below range.
   localparam int unsigned ST_ABOVE = 2; // Last value was above range.
   localparam int unsigned ST_BUFERR = 3; // Sticky window allocation error.
   localparam int unsigned ST_HOLD = 4; // Output currently held.
   // Values after reset.
   localparam logic [31:0] CTRL_RST = 32'h0001_0000; // Interval count, window 1.
   localparam logic [15:0] FILTER_RST = 16'h000a; // Debounce filter time.
   localparam logic [15:0] CYCLE_RST = 16'h0001; // Measurement cycle length.
   localparam logic [16:0] DAYRST_RST = 17'h00000; // Clear at midnight.
   // Hold settings and range limits.
   localparam logic [2:0] HOLD_OFF = 3'h0; // No hold.
   localparam logic [2:0] HOLD_MAX = 3'h5; // Largest counted hold.
   localparam logic [2:0] HOLD_PERM = 3'h7; // Hold until next good value.
   localparam int unsigned FREQ_LO_HZ = 1; // Lower range limit in Hz.
   localparam int unsigned FREQ_HI_HZ = 1000; // Upper range limit in Hz.
   localparam logic [31:0] BELOW_RANGE_CODE = 32'hffff_fff1; // Below-range error.
   localparam logic [31:0] ABOVE_RANGE_CODE = 32'hffff_fff2; // Above-range error.
   // Input modes, reductions and range handling.
   typedef enum logic [1:0] {MODE_INTERVAL, MODE_DAY, MODE_FREQ} pfi_mode_e;
   typedef enum logic [2:0] {RED_OFF, RED_MIN, RED_MAX, RED_MEAN, RED_MEDIAN,
      RED_RMS} pfi_red_e;
   typedef enum logic [1:0] {RNG_IGNORE, RNG_CUTOFF, RNG_OUT, RNG_STDLIM} pfi_rng_e;
endpackage : pfi_pkg

// *** src/pfi_top.sv ***
// Pulse counter and frequency meter input with reduction, hold and range handling.
// How it works
// - Interval count clears at each produced value.
// - Daily count sums pulses until reset time.
// - Interval mode records only latest cycle count.
// - Level change accepted after stable filter time.
// - Reduction off, minimum or maximum selectable.
// - Mean reduction records window arithmetic average.
// - Median reduction records window median.
// - Rms reduction records root mean square.
// - Window too large raises allocation error event.
// - Hold counts keep last good, then error.
// - Permanent hold keeps last good until valid.
// - Ignore handling outputs frequency beyond limits.
// - Silent cutoff clamps frequency to limits.
// - Below 1Hz gives below-range code.
// - Above 1000Hz gives above-range code.
// - Daily clear time is configurable.
`timescale 1ns/10ps
`default_nettype none
module pfi_top #(
   parameter int unsigned MS_CYCLES = pfi_pkg::MS_CYCLES, // Clocks per ms tick.
   parameter int unsigned WIN_DEPTH = 8, // Entries of the reduction window.
   parameter int unsigned DW = 24 // Width of measurement values.
) (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Asynchronous reset, active high.
   input wire logic hsel_i, // Slave select.
   input wire logic [31:0] haddr_i, // Byte address.
   input wire logic [1:0] htrans_i, // Transfer type.
   input wire logic hwrite_i, // Write when high.
   input wire logic [2:0] hsize_i, // Transfer size, word only.
   input wire logic [31:0] hwdata_i, // Write data.
   input wire logic hready_i, // Bus ready.
   output logic hreadyout_o, // Slave ready.
   output logic hresp_o, // Response, always OKAY.
   output logic [31:0] hrdata_o, // Read data.
   input wire logic pulse_i, // Pulse or frequency input pin.
   output logic [31:0] value_o, // Processed value or error code.
   output logic value_valid_o, // One-cycle pulse with each new value.
   output logic value_err_o, // Value is an error code.
   output logic buf_err_o // One-cycle allocation error event.
);
   localparam int unsigned WW = $clog2(WIN_DEPTH + 1); // Width of window counts.
   localparam int unsigned SW = DW + WW; // Width of window sums.
   localparam int unsigned QW = 2 * DW + WW; // Width of square sums.
   localparam logic [DW-1:0] DMAX = '1; // Saturation value of counters.

   // Refuse shapes the arithmetic cannot serve.
   if (WIN_DEPTH < 2 || WIN_DEPTH > 15 || DW < 11 || DW > 32 || MS_CYCLES < 2)
   begin : g_bad_cfg
      $error("pfi_top: unsupported parameter values");
   end

   // Bus and configuration state.
   logic [31:0] ctrl_q; // Control register.
   logic [15:0] filter_q; // Filter time in ms.
   logic [15:0] cycle_q; // Measurement cycle in seconds.
   logic [16:0] tod_q; // Time of day in seconds.
   logic [16:0] dayrst_q; // Daily clear time in seconds.
   logic wr_q; // Pending write data phase.
   logic [7:0] addr_q; // Address of pending write.
   logic [31:0] hrdata_q; // Read data register.
   logic buferr_st_q; // Sticky allocation error.
   logic buf_err_q; // Allocation error event.
   pfi_pkg::pfi_mode_e mode; // Selected input mode.
   pfi_pkg::pfi_red_e red; // Selected reduction.
   pfi_pkg::pfi_rng_e rng; // Selected range handling.
   logic [2:0] hold_cfg; // Hold setting.
   logic [3:0] win_cfg; // Requested window length.
   logic bus_take; // Address phase accepted.
   logic status_wr; // Write to the status register.

   assign mode = pfi_pkg::pfi_mode_e'(ctrl_q[pfi_pkg::CTRL_MODE_LSB +: 2]);
   assign red = pfi_pkg::pfi_red_e'(ctrl_q[pfi_pkg::CTRL_RED_LSB +: 3]);
   assign hold_cfg = ctrl_q[pfi_pkg::CTRL_HOLD_LSB +: 3];
   assign rng = pfi_pkg::pfi_rng_e'(ctrl_q[pfi_pkg::CTRL_RNG_LSB +: 2]);
   assign win_cfg = ctrl_q[pfi_pkg::CTRL_WIN_LSB +: 4];
   assign bus_take = hsel_i && htrans_i[1] && hready_i;
   assign status_wr = wr_q && (addr_q == pfi_pkg::OFF_STATUS);
   assign hreadyout_o = 1'b1; // Every access completes without wait states.
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_q;

   // Timebase: ms tick from the clock, second tick from ms ticks.
   logic [$clog2(MS_CYCLES)-1:0] div_q; // Clock divider.
   logic [9:0] ms_q; // Ms within the second.
   logic ms_tick; // One-cycle ms enable.
   logic sec_tick; // One-cycle second enable.
   assign ms_tick = (div_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
   assign sec_tick = ms_tick && (ms_q == 10'(pfi_pkg::MS_PER_S - 1));

   // Divider counters; only count, never written by software.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         div_q <= '0;
         ms_q <= '0;
      end
      else
      begin
         div_q <= ms_tick ? '0 : div_q + 1'b1;
         if (ms_tick)
            ms_q <= sec_tick ? '0 : ms_q + 1'b1;
      end
   end

   // Input synchroniser, three stages; only the last two are compared.
   logic [2:0] sync_q; // Synchroniser chain.
   logic db_q; // Debounced level.
   logic [15:0] flt_q; // Ms the new level has held.
   logic edge_r; // Debounced rising edge.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         sync_q <= '0;
      else
         sync_q <= {sync_q[1:0], pulse_i};
   end

   // Debounce: the settled level must differ for the whole filter time.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         db_q <= 1'b0;
         flt_q <= '0;
      end
      else if (sync_q[1] != sync_q[2] || sync_q[2] == db_q)
         flt_q <= '0; // Glitch or no change restarts the filter.
      else if (flt_q >= filter_q)
      begin
         db_q <= sync_q[2]; // Level held long enough.
         flt_q <= '0;
      end
      else if (ms_tick)
         flt_q <= flt_q + 1'b1;
   end
   assign edge_r = (sync_q[1] == sync_q[2]) && sync_q[2] && !db_q &&
      (flt_q >= filter_q);

   // Measurement cycle timer in whole seconds.
   logic [15:0] cyc_q; // Seconds elapsed in this cycle.
   logic cyc_tick; // Cycle end, one cycle.
   assign cyc_tick = sec_tick && (cyc_q + 16'h0001 >= cycle_q);
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         cyc_q <= '0;
      else if (sec_tick)
         cyc_q <= cyc_tick ? '0 : cyc_q + 1'b1;
   end

   // Pulse accumulators; an edge in the clearing cycle opens the new total.
   logic [DW-1:0] icnt_q; // Interval total.
   logic [DW-1:0] dcnt_q; // Daily total.
   logic [DW-1:0] fcnt_q; // Edges in the current second.
   logic [DW-1:0] freq_now; // Edges in the second just ending.
   logic day_clr; // Daily clear moment.
   assign day_clr = sec_tick && (tod_q == dayrst_q);
   assign freq_now = (fcnt_q == DMAX) ? DMAX : fcnt_q + DW'(edge_r);
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         icnt_q <= '0;
         dcnt_q <= '0;
         fcnt_q <= '0;
      end
      else
      begin
         if (cyc_tick)
            icnt_q <= DW'(edge_r); // Cleared with every value.
         else if (edge_r && icnt_q != DMAX)
            icnt_q <= icnt_q + 1'b1;
         if (day_clr)
            dcnt_q <= DW'(edge_r); // Total ends at the clear time.
         else if (edge_r && dcnt_q != DMAX)
            dcnt_q <= dcnt_q + 1'b1;
         if (sec_tick)
            fcnt_q <= DW'(edge_r); // One-second gate gives Hz.
         else if (edge_r && fcnt_q != DMAX)
            fcnt_q <= fcnt_q + 1'b1;
      end
   end

   // Raw sample and range verdict at each cycle end.
   logic [DW-1:0] raw; // Sample of the selected mode.
   logic below; // Frequency under the lower limit.
   logic above; // Frequency over the upper limit.
   always_comb
   begin
      below = 1'b0;
      above = 1'b0;
      case (mode)
         pfi_pkg::MODE_INTERVAL: raw = icnt_q + DW'(edge_r); // Latest cycle only.
         pfi_pkg::MODE_DAY: raw = dcnt_q;
         pfi_pkg::MODE_FREQ:
         begin
            raw = freq_now;
            if (rng == pfi_pkg::RNG_CUTOFF)
            begin
               // Clamp to the nearest limit.
               if (freq_now < DW'(pfi_pkg::FREQ_LO_HZ))
                  raw = DW'(pfi_pkg::FREQ_LO_HZ);
               else if (freq_now > DW'(pfi_pkg::FREQ_HI_HZ))
                  raw = DW'(pfi_pkg::FREQ_HI_HZ);
            end
            else if (rng != pfi_pkg::RNG_IGNORE)
            begin
               below = freq_now < DW'(pfi_pkg::FREQ_LO_HZ);
               above = freq_now > DW'(pfi_pkg::FREQ_HI_HZ);
            end
         end
         default: raw = '0;
      endcase
   end

   // Reduction window; only good samples enter it.
   logic [DW-1:0] win_q [WIN_DEPTH]; // Newest entry at index zero.
   logic [WW-1:0] fill_q; // Entries holding samples.
   logic samp_bad_q; // Sample of this cycle was out of range.
   logic samp_below_q; // Out of range on the low side.
   logic stage_q; // Window updated, reduce now.
   for (genvar g = 0; g < WIN_DEPTH; g++)
   begin : g_win
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
            win_q[g] <= '0;
         else if (cyc_tick && !below && !above)
            win_q[g] <= (g == 0) ? raw : win_q[(g == 0) ? 0 : g - 1];
      end
   end

   // Window fill, sample verdict and allocation error.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fill_q <= '0;
         samp_bad_q <= 1'b0;
         samp_below_q <= 1'b0;
         stage_q <= 1'b0;
         buf_err_q <= 1'b0;
      end
      else
      begin
         stage_q <= cyc_tick;
         buf_err_q <= cyc_tick && red != pfi_pkg::RED_OFF &&
            32'(win_cfg) > WIN_DEPTH; // No room for more entries.
         if (cyc_tick)
         begin
            samp_bad_q <= below || above;
            samp_below_q <= below;
            if (!below && !above && fill_q != WW'(WIN_DEPTH))
               fill_q <= fill_q + 1'b1;
         end
      end
   end

   // Window statistics over the newest n entries.
   logic [WW-1:0] n; // Entries taken into account.
   logic [DW-1:0] rmin; // Smallest entry.
   logic [DW-1:0] rmax; // Largest entry.
   logic [SW-1:0] rsum; // Sum of entries.
   logic [QW-1:0] rsq; // Sum of squares.
   logic [DW-1:0] rmed; // Lower median.
   logic [DW-1:0] red_val; // Reduced value.
   always_comb
   begin
      logic [WW-1:0] want;
      logic [WW-1:0] rank;
      rank = '0;
      want = (win_cfg == 4'h0) ? WW'(1) :
         (32'(win_cfg) > WIN_DEPTH) ? WW'(WIN_DEPTH) : WW'(win_cfg);
      n = (fill_q < want) ? fill_q : want;
      if (n == '0)
         n = WW'(1);
      rmin = DMAX;
      rmax = '0;
      rsum = '0;
      rsq = '0;
      rmed = '0;
      for (int i = 0; i < WIN_DEPTH; i++)
      begin
         if (i < 32'(n))
         begin
            if (win_q[i] < rmin) rmin = win_q[i];
            if (win_q[i] > rmax) rmax = win_q[i];
            rsum = rsum + SW'(win_q[i]);
            rsq = rsq + QW'(win_q[i]) * QW'(win_q[i]);
            rank = '0;
            for (int j = 0; j < WIN_DEPTH; j++)
               if (j < 32'(n) && (win_q[j] < win_q[i] ||
                  (win_q[j] == win_q[i] && j < i)))
                  rank = rank + 1'b1;
            if (rank == (n - 1'b1) >> 1)
               rmed = win_q[i]; // Entry with middle rank.
         end
      end
      case (red)
         pfi_pkg::RED_OFF: red_val = win_q[0]; // Passed unchanged.
         pfi_pkg::RED_MIN: red_val = rmin;
         pfi_pkg::RED_MAX: red_val = rmax;
         pfi_pkg::RED_MEAN: red_val = DW'(rsum / SW'(n));
         pfi_pkg::RED_MEDIAN: red_val = rmed;
         pfi_pkg::RED_RMS: red_val = DW'(isqrt(64'(rsq / QW'(n))));
         default: red_val = win_q[0];
      endcase
   end

   // Integer square root, bit by bit from the top.
   function automatic logic [31:0] isqrt(input logic [63:0] a);
      logic [31:0] r;
      logic [31:0] t;
      r = '0;
      for (int b = 31; b >= 0; b--)
      begin
         t = r | (32'h1 << b);
         if (64'(t) * 64'(t) <= a)
            r = t;
      end
      return r;
   endfunction : isqrt

   // Output stage with hold of the last good value.
   logic [31:0] value_q; // Output value.
   logic valid_q; // New value pulse.
   logic err_q; // Output is an error code.
   logic err_below_q; // Error is below range.
   logic held_q; // Output is a held value.
   logic have_good_q; // A good value exists.
   logic [2:0] errcnt_q; // Erroneous cycles held so far.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         value_q <= '0;
         valid_q <= 1'b0;
         err_q <= 1'b0;
         err_below_q <= 1'b0;
         held_q <= 1'b0;
         have_good_q <= 1'b0;
         errcnt_q <= '0;
      end
      else
      begin
         valid_q <= stage_q;
         if (stage_q && !samp_bad_q)
         begin
            value_q <= 32'(red_val); // A good value ends any hold.
            err_q <= 1'b0;
            held_q <= 1'b0;
            have_good_q <= 1'b1;
            errcnt_q <= '0;
         end
         else if (stage_q)
         begin
            err_below_q <= samp_below_q;
            if (have_good_q && (hold_cfg == pfi_pkg::HOLD_PERM ||
               (hold_cfg != pfi_pkg::HOLD_OFF && hold_cfg <= pfi_pkg::HOLD_MAX &&
               errcnt_q < hold_cfg)))
            begin
               errcnt_q <= errcnt_q + 3'(hold_cfg != pfi_pkg::HOLD_PERM);
               held_q <= 1'b1; // value_q keeps the last good value.
            end
            else
            begin
               // Hold spent or off: the error code goes out.
               value_q <= samp_below_q ? pfi_pkg::BELOW_RANGE_CODE :
                  pfi_pkg::ABOVE_RANGE_CODE;
               err_q <= 1'b1;
               held_q <= 1'b0;
            end
         end
      end
   end
   assign value_o = value_q;
   assign value_valid_o = valid_q;
   assign value_err_o = err_q;
   assign buf_err_o = buf_err_q;

   // Bus slave: address phase captured, write performed in the data phase.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_q <= 1'b0;
         addr_q <= '0;
         hrdata_q <= '0;
      end
      else if (hready_i)
      begin
         wr_q <= bus_take && hwrite_i;
         addr_q <= haddr_i[7:0];
         if (bus_take && !hwrite_i)
         begin
            // Read data is fetched here so it stands through the data phase.
            case (haddr_i[7:0]) // Upper address bits are not decoded, as for writes.
               pfi_pkg::OFF_CTRL: hrdata_q <= ctrl_q;
               pfi_pkg::OFF_FILTER: hrdata_q <= 32'(filter_q);
               pfi_pkg::OFF_CYCLE: hrdata_q <= 32'(cycle_q);
               pfi_pkg::OFF_TOD: hrdata_q <= 32'(tod_q);
               pfi_pkg::OFF_DAYRST: hrdata_q <= 32'(dayrst_q);
               pfi_pkg::OFF_VALUE: hrdata_q <= value_q;
               pfi_pkg::OFF_STATUS: hrdata_q <= {27'h0, held_q, buferr_st_q,
                  err_q && !err_below_q, err_q && err_below_q, err_q};
               pfi_pkg::OFF_LIVE: hrdata_q <= 32'(raw);
               default: hrdata_q <= '0; // Unmapped reads as zero.
            endcase
         end
      end
   end

   // Software registers; the clock advances the time of day.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= pfi_pkg::CTRL_RST;
         filter_q <= pfi_pkg::FILTER_RST;
         cycle_q <= pfi_pkg::CYCLE_RST;
         tod_q <= '0;
         dayrst_q <= pfi_pkg::DAYRST_RST;
      end
      else
      begin
         if (wr_q && addr_q == pfi_pkg::OFF_CTRL) ctrl_q <= hwdata_i;
         if (wr_q && addr_q == pfi_pkg::OFF_FILTER) filter_q <= hwdata_i[15:0];
         if (wr_q && addr_q == pfi_pkg::OFF_CYCLE)
            cycle_q <= (hwdata_i[15:0] == '0) ? 16'h0001 : hwdata_i[15:0];
         if (wr_q && addr_q == pfi_pkg::OFF_DAYRST)
            dayrst_q <= hwdata_i[16:0];
         if (wr_q && addr_q == pfi_pkg::OFF_TOD)
            tod_q <= hwdata_i[16:0];
         else if (sec_tick)
            tod_q <= (tod_q == 17'(pfi_pkg::SEC_PER_DAY - 1)) ? '0 : tod_q + 1'b1;
      end
   end

   // Sticky allocation error: a new event wins over a write-one clear.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         buferr_st_q <= 1'b0;
      else if (buf_err_q)
         buferr_st_q <= 1'b1;
      else if (status_wr && hwdata_i[pfi_pkg::ST_BUFERR])
         buferr_st_q <= 1'b0;
   end
endmodule : pfi_top
`default_nettype wire

// *** tb/pfi_top_assertions.sv ***
// Concurrent checks on the ports of the pulse and frequency input block.
`timescale 1ns/10ps
`default_nettype none
module pfi_top_chk (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Reset, active high.
   input wire logic hsel_i, // Bus select.
   input wire logic [1:0] htrans_i, // Transfer type.
   input wire logic hwrite_i, // Write when high.
   input wire logic hready_i, // Bus ready.
   input wire logic hreadyout_o, // Slave ready.
   input wire logic hresp_o, // Slave response.
   input wire logic [31:0] hrdata_o, // Read data.
   input wire logic [31:0] value_o, // Processed value.
   input wire logic value_valid_o, // New value strobe.
   input wire logic value_err_o, // Value is an error code.
   input wire logic buf_err_o // Window allocation event.
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // A window error is a lone pulse that leads the new value by one clock.
   sequence s_cycle_end;
      buf_err_o ##1 (value_valid_o && !buf_err_o);
   endsequence
   AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
      else $error("slave stalled or flagged an error");
   AST_HRDATA_STANDS: assert property ($changed(hrdata_o) |->
      $past(hsel_i && htrans_i[1] && hready_i && !hwrite_i))
      else $error("read data moved without an accepted read");
   AST_VALID_ONE_CYCLE: assert property (value_valid_o |=> !value_valid_o [*8])
      else $error("value strobe longer than one clock");
   AST_BUF_BEFORE_VALUE: assert property (buf_err_o |-> s_cycle_end)
      else $error("window error not followed by a value");
   AST_BELOW_FLAGGED: assert property ((value_o == pfi_pkg::BELOW_RANGE_CODE) |-> value_err_o)
      else $error("below-range code without error flag");
   AST_ABOVE_FLAGGED: assert property ((value_o == pfi_pkg::ABOVE_RANGE_CODE) |-> value_err_o)
      else $error("above-range code without error flag");
   AST_ERR_IS_CODE: assert property (value_err_o |->
      (value_o == pfi_pkg::BELOW_RANGE_CODE || value_o == pfi_pkg::ABOVE_RANGE_CODE))
      else $error("error flag on an ordinary value");
   AST_VALUE_HELD: assert property (!value_valid_o |-> $stable(value_o) && $stable(value_err_o))
      else $error("value changed between measurement cycles");
endmodule : pfi_top_chk
bind pfi_top pfi_top_chk i_chk (.clk_i, .rst_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
   .hreadyout_o, .hresp_o, .hrdata_o, .value_o, .value_valid_o, .value_err_o, .buf_err_o);
`default_nettype wire

// *** tb/pfi_pulse_src.sv ***
// Behavioural external pulse source feeding the input pin.
`timescale 1ns/10ps
`default_nettype none
module pfi_pulse_src (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Restarts the phase.
   input wire logic en_i, // Run the square wave.
   input wire logic glitch_i, // Emit short spikes only.
   output logic pulse_o // Level toward the input pin.
);
   logic [5:0] ph_q; // Phase within a 40-clock period.
   // Phase follows reset, so edges stay clear of the second ticks.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ph_q <= 6'h00;
      else
         ph_q <= (ph_q == 6'h27) ? 6'h00 : ph_q + 6'h01;
   end
   // A spike lasts 2 clocks, shorter than the debounce time; a pulse lasts 12.
   assign pulse_o = en_i && (ph_q >= 6'h18) && (ph_q < (glitch_i ? 6'h1a : 6'h24));
endmodule : pfi_pulse_src
`default_nettype wire

// *** tb/tb_pfi_top.sv ***
// Self-checking bench for the pulse and frequency input block.
`timescale 1ns/10ps
`default_nettype none
module tb_pfi_top;
   logic clk_i = 1'b0; // System clock.
   logic rst_i = 1'b1; // Reset.
   logic hsel_i = 1'b0; // Bus select.
   logic hwrite_i = 1'b0; // Write.
   logic [1:0] htrans_i = 2'h0; // Transfer type.
   logic [31:0] haddr_i = 32'h0; // Address.
   logic [31:0] hwdata_i = 32'h0; // Write data.
   logic src_en = 1'b0; // Source runs.
   logic src_gl = 1'b0; // Source spikes only.
   logic pulse; // Input pin level.
   logic hreadyout_o, hresp_o, value_valid_o, value_err_o, buf_err_o; // Outputs.
   logic [31:0] hrdata_o, value_o, v1; // Read data, value and a saved total.
   int miscompares = 0; // Mismatches.
   int n_tests = 0; // Comparisons.
   // Off, min, max, mean, lower median and rms of the window {50, 0}.
   logic [31:0] red_exp [6] = '{32'h0, 32'h0, 32'h32, 32'h19, 32'h0, 32'h23};
   logic [2:0] hl [3] = '{3'h0, 3'h1, 3'h7}; // Hold settings.
   always #10 clk_i = ~clk_i;
   pfi_pulse_src i_src (.clk_i, .rst_i, .en_i(src_en), .glitch_i(src_gl), .pulse_o(pulse));
   // A short millisecond keeps one second at 2000 clocks.
   pfi_top #(.MS_CYCLES(2)) i_dut (.clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o,
      .pulse_i(pulse), .value_o, .value_valid_o, .value_err_o, .buf_err_o);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One single transfer; a read compares its data with d.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      haddr_i <= {24'h0, a};
      htrans_i <= 2'h2;
      hwrite_i <= w;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      if (!w)
         chk(hrdata_o, d);
   endtask : bus
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] r,
      input logic [2:0] h, input logic [1:0] g, input logic [3:0] x);
      return {12'h0, x, 6'h0, g, h, r, m};
   endfunction : ctl
   // Sets the source, then waits for the next value and checks it if asked.
   task automatic step(input logic en, input logic gl, input logic ck, input logic [31:0] ev,
      input logic ee);
      src_en <= en;
      src_gl <= gl;
      do @(posedge clk_i); while (value_valid_o !== 1'b1);
      if (ck)
      begin
         chk(value_o, ev);
         chk({31'h0, value_err_o}, {31'h0, ee});
      end
   endtask : step
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   // A hang costs a mismatch; the run needs about 64000 clocks.
   initial
   begin
      #1600000;
      miscompares++;
      wrap_up();
   end
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, pfi_pkg::OFF_CTRL, pfi_pkg::CTRL_RST);
      bus(1'b0, pfi_pkg::OFF_FILTER, {16'h0, pfi_pkg::FILTER_RST});
      bus(1'b0, pfi_pkg::OFF_DAYRST, 32'h0);
      bus(1'b1, 8'h20, 32'hffff_ffff);
      bus(1'b0, 8'h20, 32'h0);
      bus(1'b1, pfi_pkg::OFF_FILTER, 32'h2);
      bus(1'b1, pfi_pkg::OFF_CTRL, ctl(2'h0, 3'h0, 3'h0, 2'h0, 4'h1));
      step(1'b1, 1'b0, 1'b0, 32'h0, 1'b0);
      step(1'b1, 1'b0, 1'b1, 32'h32, 1'b0);
      step(1'b1, 1'b1, 1'b1, 32'h0, 1'b0);
      for (int r = 0; r < 6; r++)
      begin
         bus(1'b1, pfi_pkg::OFF_CTRL, ctl(2'h0, r[2:0], 3'h0, 2'h0, 4'h2));
         step(1'b1, 1'b0, 1'b0, 32'h0, 1'b0);
         step(1'b0, 1'b0, 1'b1, red_exp[r], 1'b0);
      end
      bus(1'b1, pfi_pkg::OFF_CTRL, ctl(2'h1, 3'h0, 3'h0, 2'h0, 4'h1));
      step(1'b1, 1'b0, 1'b0, 32'h0, 1'b0);
      v1 = value_o;
      step(1'b1, 1'b0, 1'b1, v1 + 32'h32, 1'b0);
      bus(1'b1, pfi_pkg::OFF_DAYRST, 32'h65);
      bus(1'b1, pfi_pkg::OFF_TOD, 32'h64);
      repeat (2) step(1'b0, 1'b0, 1'b0, 32'h0, 1'b0);
      step(1'b0, 1'b0, 1'b1, 32'h0, 1'b0);
      foreach (hl[i])
      begin
         bus(1'b1, pfi_pkg::OFF_CTRL, ctl(2'h2, 3'h0, hl[i], {1'b1, hl[i] == 3'h0}, 4'h1));
         step(1'b1, 1'b0, 1'b1, 32'h32, 1'b0);
         step(1'b0, 1'b0, 1'b1, (hl[i] == 3'h0) ? pfi_pkg::BELOW_RANGE_CODE : 32'h32,
            hl[i] == 3'h0);
         step(1'b0, 1'b0, 1'b1, (hl[i] == 3'h7) ? 32'h32 : pfi_pkg::BELOW_RANGE_CODE,
            hl[i] != 3'h7);
      end
      bus(1'b1, pfi_pkg::OFF_CTRL, ctl(2'h0, 3'h2, 3'h0, 2'h0, 4'hf));
      step(1'b0, 1'b0, 1'b0, 32'h0, 1'b0);
      bus(1'b0, pfi_pkg::OFF_STATUS, 32'h8);
      bus(1'b1, pfi_pkg::OFF_CTRL, ctl(2'h2, 3'h0, 3'h0, 2'h0, 4'h1));
      step(1'b0, 1'b0, 1'b1, 32'h0, 1'b0);
      bus(1'b1, pfi_pkg::OFF_CTRL, ctl(2'h2, 3'h0, 3'h0, 2'h1, 4'h1));
      step(1'b0, 1'b0, 1'b1, 32'h1, 1'b0);
      wrap_up();
   end
endmodule : tb_pfi_top
`default_nettype wire
